/* rtl/jksr_first_stage.sv */
`timescale 1ns/10ps
`default_nettype none
module jksr_first_stage
  import jksr_pkg::*;
(
  input  wire logic i_j,
  input  wire logic i_k_n,
  input  wire logic i_cur,
  output var  logic o_next
);
  jksr_act_e act;

  // ----------------------------------------------------------------
  // Serial J and inverted-K decode
  // ----------------------------------------------------------------
  always_comb begin
    act = JKSR_ACT_HOLD;
    if (!i_j && i_k_n) begin
      act = JKSR_ACT_HOLD;
    end else if (!i_j && !i_k_n) begin
      act = JKSR_ACT_CLEAR;
    end else if (i_j && i_k_n) begin
      act = JKSR_ACT_SET;
    end else begin
      act = JKSR_ACT_TOGGLE;
    end
  end

  always_comb begin
    case (act)
      JKSR_ACT_HOLD:   o_next = i_cur;
      JKSR_ACT_CLEAR:  o_next = 1'b0;
      JKSR_ACT_SET:    o_next = 1'b1;
      JKSR_ACT_TOGGLE: o_next = ~i_cur;
      default:         o_next = i_cur;
    endcase
  end
endmodule
`default_nettype wire

/* rtl/jksr_pkg.sv */
`default_nettype none
package jksr_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          JKSR_WIDTH    = 4;
  localparam logic [3:0]  JKSR_RST_VAL  = 4'h0;
  localparam logic        JKSR_NRST_VAL = 1'b1;
  localparam int          JKSR_LAST_POS = 3;
  localparam int          JKSR_FIRST_POS = 0;
  // ----------------------------------------------------------------
  // First stage serial actions
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    JKSR_ACT_HOLD   = 4'h1,
    JKSR_ACT_CLEAR  = 4'h2,
    JKSR_ACT_SET    = 4'h4,
    JKSR_ACT_TOGGLE = 4'h8
  } jksr_act_e;
endpackage
`default_nettype wire

/* rtl/jksr_shift_reg.sv */
`timescale 1ns/10ps
`default_nettype none
module jksr_shift_reg
  import jksr_pkg::*;
#(
  parameter int WIDTH = JKSR_WIDTH
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  input  wire logic             i_clear_low,
  input  wire logic             i_shift_nload,
  input  wire logic             i_serial_j,
  input  wire logic             i_serial_k_n,
  input  wire logic [WIDTH-1:0] i_par_data,
  output var  logic [WIDTH-1:0] o_stage_q,
  output var  logic             o_first_stage_out,
  output var  logic             o_last_stage_out,
  output var  logic             o_last_stage_out_n
);
  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage_q;
  logic [WIDTH-1:0] stage_d;
  logic             last_n_q;
  logic             last_n_d;
  logic             first_next;
  logic             clr_async;
  logic             do_load;
  logic             do_shift;

  // ----------------------------------------------------------------
  // Clear and mode decode
  // ----------------------------------------------------------------
  // Board clear and system reset share the flop clear pins
  assign clr_async = i_sys_rst | ~i_clear_low;
  assign do_load   = i_clk_en & ~i_shift_nload;
  assign do_shift  = i_clk_en & i_shift_nload;

  // ----------------------------------------------------------------
  // First stage serial logic
  // ----------------------------------------------------------------
  jksr_first_stage u_first (
    .i_j    (i_serial_j),
    .i_k_n  (i_serial_k_n),
    .i_cur  (stage_q[0]),
    .o_next (first_next)
  );

  // ----------------------------------------------------------------
  // Stage group
  // ----------------------------------------------------------------
  // Load wins over shift; enable low keeps every stage
  always_comb begin
    stage_d = stage_q;
    if (do_load) begin
      stage_d = i_par_data;
    end else if (do_shift) begin
      stage_d = {stage_q[WIDTH-2:0], first_next};
    end
  end

  always_ff @(posedge i_clk_sys or posedge clr_async) begin
    if (clr_async) begin
      stage_q <= WIDTH'(JKSR_RST_VAL);
    end else begin
      stage_q <= stage_d;
    end
  end

  // ----------------------------------------------------------------
  // Load checks
  // ----------------------------------------------------------------
  a_load_data: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_load |=> (o_stage_q == $past(i_par_data))
  ) else $error("Parallel load mismatch");

  a_load_first: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_load |=> (o_first_stage_out == $past(i_par_data[0]))
  ) else $error("First stage not loaded from data");

  a_load_no_serial: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    (do_load && !i_par_data[0] && i_serial_j) |=> !o_first_stage_out
  ) else $error("Serial data entered during load");

  a_load_no_clear: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    (do_load && i_par_data[0] && !i_serial_j && !i_serial_k_n) |=> o_first_stage_out
  ) else $error("Serial clear acted during load");

  // ----------------------------------------------------------------
  // Shift checks
  // ----------------------------------------------------------------
  a_shift_move: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_shift |=> (o_stage_q[WIDTH-1:1] == $past(o_stage_q[WIDTH-2:0]))
  ) else $error("Shift did not move stages");

  a_shift_first: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_shift |=> (o_first_stage_out == (($past(i_serial_j) & ~$past(o_first_stage_out)) |
                                        ($past(i_serial_k_n) & $past(o_first_stage_out))))
  ) else $error("First stage serial value wrong");

  a_jk_hold: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    (do_shift && !i_serial_j && i_serial_k_n) |=> $stable(o_first_stage_out)
  ) else $error("JK hold failed");

  a_jk_clear: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    (do_shift && !i_serial_j && !i_serial_k_n) |=> !o_first_stage_out
  ) else $error("JK clear failed");

  a_jk_set: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    (do_shift && i_serial_j && i_serial_k_n) |=> o_first_stage_out
  ) else $error("JK set failed");

  a_jk_toggle: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    (do_shift && i_serial_j && !i_serial_k_n) |=> (o_first_stage_out != $past(o_first_stage_out))
  ) else $error("JK toggle failed");

  // ----------------------------------------------------------------
  // Freeze checks
  // ----------------------------------------------------------------
  a_freeze_en: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    !i_clk_en |=> $stable(o_stage_q)
  ) else $error("State changed with enable low");

  // ----------------------------------------------------------------
  // Complement group
  // ----------------------------------------------------------------
  always_comb begin
    last_n_d = last_n_q;
    if (i_clk_en) begin
      last_n_d = ~stage_d[WIDTH-1];
    end
  end

  always_ff @(posedge i_clk_sys or posedge clr_async) begin
    if (clr_async) begin
      last_n_q <= JKSR_NRST_VAL;
    end else begin
      last_n_q <= last_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Complement checks
  // ----------------------------------------------------------------
  a_compl_out: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    o_last_stage_out_n == ~o_last_stage_out
  ) else $error("Complement output wrong");

  a_load_compl: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_load |=> (o_last_stage_out_n == ~$past(i_par_data[WIDTH-1]))
  ) else $error("Complement wrong after load");

  a_shift_compl: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_shift |=> (o_last_stage_out_n == ~$past(o_stage_q[WIDTH-2]))
  ) else $error("Complement wrong after shift");

  a_freeze_compl: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    !i_clk_en |=> $stable(o_last_stage_out_n)
  ) else $error("Complement changed with enable low");

  // ----------------------------------------------------------------
  // Clear checks
  // ----------------------------------------------------------------
  a_clear_hold: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_clear_low |-> (o_stage_q == WIDTH'(JKSR_RST_VAL) && o_last_stage_out_n)
  ) else $error("Clear did not force outputs");

  a_clear_first: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_clear_low |-> (!o_first_stage_out && !o_last_stage_out)
  ) else $error("Clear did not force stage taps low");

  a_clear_ovr: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ((!i_clear_low && i_clk_en) ##1 !i_clear_low) |-> (o_stage_q == WIDTH'(JKSR_RST_VAL))
  ) else $error("Clock edge acted during clear");

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_stage_q          = stage_q;
  assign o_first_stage_out  = stage_q[0];
  assign o_last_stage_out   = stage_q[WIDTH-1];
  assign o_last_stage_out_n = last_n_q;

  // ----------------------------------------------------------------
  // Output checks
  // ----------------------------------------------------------------
  a_load_last: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_load |=> (o_last_stage_out == $past(i_par_data[WIDTH-1]))
  ) else $error("Last stage not loaded from data");

  a_shift_last: assert property (
    @(posedge i_clk_sys) disable iff (clr_async)
    do_shift |=> (o_last_stage_out == $past(o_stage_q[WIDTH-2]))
  ) else $error("Last stage not fed from stage before it");
endmodule
`default_nettype wire

/* tb/jksr_board.sv */
`timescale 1ns/10ps
`default_nettype none
module jksr_board (
  input  wire logic       i_clk_sys,
  output var  logic       o_en,
  output var  logic       o_clear_low,
  output var  logic       o_sh,
  output var  logic       o_j,
  output var  logic       o_k_n,
  output var  logic [3:0] o_par
);
  initial begin
    o_en = 1'b1;
    o_clear_low = 1'b1;
    {o_sh, o_j, o_k_n, o_par} = 7'h00;
  end
  // Called just after a rising edge; values stand until the next call
  task automatic drive(input logic s, input logic j, input logic k, input logic [3:0] d);
    {o_sh, o_j, o_k_n, o_par} = {s, j, k, d};
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import jksr_pkg::*;
  logic       clk, rst, en, clr, sh, j, kn, q0, q3, q3n;
  logic [3:0] par, q, e;
  int         n_fail = 0;
  int         n_checks = 0;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  jksr_board u_board (.i_clk_sys(clk), .o_en(en), .o_clear_low(clr), .o_sh(sh),
    .o_j(j), .o_k_n(kn), .o_par(par));
  jksr_shift_reg u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en), .i_clear_low(clr),
    .i_shift_nload(sh), .i_serial_j(j), .i_serial_k_n(kn), .i_par_data(par),
    .o_stage_q(q), .o_first_stage_out(q0), .o_last_stage_out(q3), .o_last_stage_out_n(q3n));
  task automatic chk(input logic [3:0] x);
    n_checks++;
    if ({q3n, q3, q0, q} !== {~x[3], x[3], x[0], x}) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, {~x[3], x[3], x[0], x}, {q3n, q3, q0, q});
    end
  endtask
  task automatic step(input logic s, input logic jj, input logic kk, input logic [3:0] d);
    u_board.drive(s, jj, kk, d);
    @(posedge clk);
    #1;
    if (!s) e = d;
    else e = {e[2:0], jj ? (kk ? 1'b1 : ~e[0]) : (kk ? e[0] : 1'b0)};
    chk(e);
  endtask
  task automatic t_load;
    step(1'b0, 1'b1, 1'b1, 4'ha);
    step(1'b0, 1'b1, 1'b0, 4'h4);
    step(1'b0, 1'b0, 1'b0, 4'h9);
    $display("test load done");
  endtask
  task automatic t_shift;
    step(1'b1, 1'b1, 1'b1, 4'h0);
    step(1'b1, 1'b1, 1'b0, 4'hf);
    step(1'b1, 1'b1, 1'b0, 4'h0);
    step(1'b1, 1'b0, 1'b1, 4'hf);
    step(1'b1, 1'b0, 1'b0, 4'h0);
    step(1'b1, 1'b1, 1'b1, 4'h0);
    $display("test shift done");
  endtask
  task automatic t_freeze;
    step(1'b0, 1'b0, 1'b0, 4'h6);
    u_board.o_en = 1'b0;
    u_board.drive(1'b0, 1'b1, 1'b1, 4'h9);
    @(posedge clk);
    #1;
    chk(e);
    u_board.drive(1'b1, 1'b1, 1'b0, 4'h9);
    @(posedge clk);
    #1;
    chk(e);
    u_board.o_en = 1'b1;
    step(1'b1, 1'b1, 1'b0, 4'h0);
    $display("test freeze done");
  endtask
  task automatic t_clear;
    step(1'b0, 1'b1, 1'b1, 4'hf);
    u_board.o_clear_low = 1'b0;
    u_board.drive(1'b1, 1'b1, 1'b1, 4'hf);
    #1;
    chk(4'h0);
    @(posedge clk);
    #1;
    chk(4'h0);
    u_board.drive(1'b0, 1'b0, 1'b1, 4'hf);
    @(posedge clk);
    #1;
    chk(4'h0);
    u_board.o_clear_low = 1'b1;
    e = 4'h0;
    step(1'b1, 1'b1, 1'b1, 4'h0);
    $display("test clear done");
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    e = 4'h0;
    repeat (8) @(posedge clk);
    #1;
    chk(4'h0);
    rst = 1'b0;
    t_load;
    t_shift;
    t_freeze;
    t_clear;
    report_and_stop;
  end
endmodule
`default_nettype wire
